// ---- rtl/crs_reset_ctrl.sv ----
`timescale 1ns/1ps
// Operation
// R1: power-good low holds every register and every domain reset.
// R2: pcie unit reset while pin low; other units reset on pin release.
// R3: pin release after d3cold exit also gives an internal reset.
// R4: in-band reset from physical-layer message or link falling to polling/detect.
// R5: d3hot to d0 with keep_config_on_wake resets csrs like port software reset.
// R6: d3hot to d0 without keep_config_on_wake resets all non-sticky function registers.
// R7: l2/l3 ready, d3cold exit, flr or pin-caused wake fully reset function.
// R8: host writes one to device control bit 15 to start flr.
// R9: after flr reload the same flash words as port software reset.
// R10: flr clears queues, interrupts, statistics, config bits, disables tx/rx flows.
// R11: flr drops pending reads; late completions discarded silently after credit update.
// R12: transactions-pending bit cleared when flr completes.
// R13: port software reset resets port logic; pcie config and dma kept.
// R14: software waits 3 ms then checks autoload and function reset done.
// R15: port software reset re-reads only function flash bits.
// R16: bus master enable low resets dma and msi only; target access stays.
// R17: master disable resets queues, dma interrupts, flows, drops pending reads.
// R18: software reinitialises queues after bus master enable returns.
// R19: flash reload request re-reads per-function flash configuration.
// R20: driver checks config load done and firmware error field after reset.
// R21: software runs master-disable handshake before d3, reset or disable.
// R22: transmit data forced to zero during port or device software reset.
// R23: sources merge into synchronised per-domain resets; power-good overrides all.
module crs_reset_ctrl
	import crs_pkg::*;
#(
	parameter int PULSE_CYC = CRS_RST_PULSE_CYC,
	parameter int TXD_W     = 8
)(
	// clock and power-good master reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// pcie side, pin is asynchronous
	input  wire logic             i_pcie_fundamental_reset_pin_n,
	input  wire logic             i_inband_reset_msg,
	input  wire logic             i_link_to_detect,
	input  wire logic             i_l23_ready_entry,
	input  wire logic             i_d3cold_exit,
	// power state and configuration writes
	input  wire logic             i_d3hot_to_d0,
	input  wire logic             i_keep_config_on_wake,
	input  wire logic             i_devctl_wr,
	input  wire logic [15:0]      i_devctl_wdata,
	input  wire logic             i_bus_master_enable,
	input  wire logic             i_trans_pending_set,
	// software control bits
	input  wire logic             i_port_software_reset,
	input  wire logic             i_device_software_reset,
	input  wire logic             i_flash_reload_request,
	// flash autoload engine
	input  wire logic             i_flash_word_ack,
	input  wire logic             i_flash_err,
	// transmit data from the mac
	input  wire logic [TXD_W-1:0] i_txd,
	// domain resets, active low
	output logic                  o_pcie_rst_n,
	output logic                  o_port_rst_n,
	output logic                  o_dma_rst_n,
	output logic                  o_cfg_nonsticky_rst_n,
	output logic                  o_func_rst_n,
	// flow and read control
	output logic                  o_flows_disable,
	output logic                  o_drop_pending_reads,
	output logic                  o_discard_unexpected_cpl,
	output logic                  o_msi_disable,
	// flash load request
	output logic                  o_flash_load_req,
	output logic [7:0]            o_flash_load_words,
	output logic                  o_flash_load_func_only,
	// status
	output logic                  o_config_load_done,
	output logic                  o_autoload_done,
	output logic                  o_function_reset_done,
	output logic                  o_transactions_pending,
	output logic [3:0]            o_firmware_error_indication,
	output logic                  o_flr_active,
	// transmit data toward the line
	output logic [TXD_W-1:0]      o_txd
);

	localparam int CNT_W = $clog2(PULSE_CYC + 1);

	initial begin
		if (PULSE_CYC < 1 || TXD_W < 1) begin
			$error("crs_reset_ctrl: bad parameter");
		end
	end

	// pin synchroniser; first flop read only by the second
	logic pin_s1;
	logic pin_s2;
	logic pin_prev;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pin_s1   <= 1'b0;
			pin_s2   <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_s1   <= i_pcie_fundamental_reset_pin_n;
			pin_s2   <= pin_s1;
			pin_prev <= pin_s2;
		end
	end

	wire pin_asserted = !pin_s2;
	wire pin_rise     = pin_s2 && !pin_prev;

	// remember a d3cold period so its exit via the pin is a full reset
	logic in_d3cold;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			in_d3cold <= 1'b0;
		end else if (pin_rise) begin
			in_d3cold <= 1'b0;
		end else if (pin_asserted) begin
			in_d3cold <= 1'b1;
		end
	end

	// source events
	wire ev_perst   = pin_rise; // R2 R3
	wire ev_inband  = i_inband_reset_msg || i_link_to_detect; // R4
	wire ev_flr     = i_devctl_wr && i_devctl_wdata[CRS_DEVCTL_FLR_BIT]; // R8
	wire d3hot_keep = i_d3hot_to_d0 && i_keep_config_on_wake && !in_d3cold;
	wire d3hot_full = i_d3hot_to_d0 && (!i_keep_config_on_wake || in_d3cold);
	wire ev_full    = i_l23_ready_entry || i_d3cold_exit || ev_flr || d3hot_full; // R7 R6
	wire ev_swrst   = i_port_software_reset || d3hot_keep; // R5 R13
	wire ev_devrst  = i_device_software_reset;

	wire [CRS_SRC_W-1:0] src_ev = {ev_devrst, ev_swrst, ev_flr,
		d3hot_full, ev_inband, ev_perst};

	// one pulse stretcher per source
	logic [CRS_SRC_W-1:0] src_active;
	genvar g;
	generate
		for (g = 0; g < CRS_SRC_W; g++) begin : g_stretch
			logic [CNT_W-1:0] cnt;
			logic [CNT_W-1:0] next_cnt;
			assign next_cnt = src_ev[g] ? CNT_W'(PULSE_CYC) :
				(cnt != '0) ? cnt - CNT_W'(1) : cnt;
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					cnt <= '0;
				end else begin
					cnt <= next_cnt;
				end
			end
			assign src_active[g] = (cnt != '0);
		end
	endgenerate

	// full function reset also covers l2/l3 entry and d3cold exit
	logic [CNT_W-1:0] full_cnt;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			full_cnt <= '0;
		end else if (ev_full) begin
			full_cnt <= CNT_W'(PULSE_CYC); // R7
		end else if (full_cnt != '0) begin
			full_cnt <= full_cnt - CNT_W'(1);
		end
	end
	wire full_active = (full_cnt != '0);

	wire hard_active = src_active[CRS_SRC_PERST] || src_active[CRS_SRC_INBAND];
	wire bme_off     = !i_bus_master_enable;
	wire soft_active = src_active[CRS_SRC_SWRST] || src_active[CRS_SRC_DEVRST];

	// domain reset requests
	wire req_pcie   = pin_asserted || src_active[CRS_SRC_INBAND]; // R2
	wire req_port   = hard_active || soft_active || full_active; // R13
	wire req_dma    = hard_active || src_active[CRS_SRC_DEVRST] || full_active
		|| bme_off; // R16 R17
	wire req_cfgns  = hard_active || full_active; // R6 R10
	wire req_func   = hard_active || full_active || soft_active;

	// per-domain synchronised releases; i_rst_n overrides inside each
	crs_sync_rst u_sync_pcie (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_req   (req_pcie),
		.o_rst_n (o_pcie_rst_n)
	); // R23 R1
	crs_sync_rst u_sync_port (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_req   (req_port),
		.o_rst_n (o_port_rst_n)
	); // R23
	crs_sync_rst u_sync_dma (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_req   (req_dma),
		.o_rst_n (o_dma_rst_n)
	); // R23
	crs_sync_rst u_sync_cfg (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_req   (req_cfgns),
		.o_rst_n (o_cfg_nonsticky_rst_n)
	); // R23
	crs_sync_rst u_sync_func (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_req   (req_func),
		.o_rst_n (o_func_rst_n)
	); // R23

	// flr and master disable share the read drop path
	wire flr_busy = src_active[CRS_SRC_FLR];
	assign o_flr_active             = flr_busy;
	assign o_flows_disable          = flr_busy || bme_off || !o_func_rst_n; // R10 R17
	assign o_drop_pending_reads     = flr_busy || bme_off; // R11 R17
	// late completions go unexpected-silent; credits still returned elsewhere
	assign o_discard_unexpected_cpl = flr_busy || bme_off; // R11
	assign o_msi_disable            = bme_off || flr_busy; // R16

	// transmit data zeroed during software resets
	logic [TXD_W-1:0] txd_q;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			txd_q <= '0;
		end else begin
			txd_q <= soft_active ? '0 : i_txd; // R22
		end
	end
	assign o_txd = txd_q;

	// transactions pending: set wins over the clear at flr end
	logic flr_prev;
	logic tp;
	wire  flr_done = flr_prev && !flr_busy;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			flr_prev <= 1'b0;
			tp       <= 1'b0;
		end else begin
			flr_prev <= flr_busy;
			if (i_trans_pending_set) begin
				tp <= 1'b1;
			end else if (flr_done) begin
				tp <= 1'b0; // R12
			end
		end
	end
	assign o_transactions_pending = tp;

	// flash load sequencing
	crs_state_t state;
	crs_state_t next_state;
	crs_load_t  pend_kind;
	crs_load_t  cur_kind;
	logic [7:0] words_left;
	logic       func_done;
	logic [3:0] fw_err;

	wire any_rst_active = hard_active || full_active || soft_active || flr_busy;
	wire want_full = ev_perst || ev_inband;
	wire want_func = ev_flr || ev_swrst || ev_devrst || i_flash_reload_request
		|| i_d3hot_to_d0; // R9 R15 R19
	wire start_load = (pend_kind != CRS_LOAD_NONE) && !any_rst_active;
	wire last_word  = i_flash_word_ack && (words_left == 8'h01);

	always_comb begin
		next_state = state;
		unique case (state)
			CRS_ST_IDLE:  if (want_full || want_func) next_state = CRS_ST_RESET;
			CRS_ST_RESET: if (start_load) next_state = CRS_ST_LOAD;
			CRS_ST_LOAD:  if (last_word) next_state = CRS_ST_DONE;
			CRS_ST_DONE:  next_state = (pend_kind != CRS_LOAD_NONE || want_full || want_func)
				? CRS_ST_RESET : CRS_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state <= CRS_ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// power-up needs a full load; a full request beats a function one
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pend_kind <= CRS_LOAD_FULL;
		end else if (want_full) begin
			pend_kind <= CRS_LOAD_FULL;
		end else if (want_func && pend_kind == CRS_LOAD_NONE) begin
			pend_kind <= CRS_LOAD_FUNC;
		end else if (state == CRS_ST_RESET && start_load) begin
			pend_kind <= CRS_LOAD_NONE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cur_kind   <= CRS_LOAD_NONE;
			words_left <= '0;
		end else if (state == CRS_ST_RESET && start_load) begin
			cur_kind   <= pend_kind;
			words_left <= (pend_kind == CRS_LOAD_FULL) ? CRS_LOAD_FULL_WORDS
				: CRS_LOAD_FUNC_WORDS; // R9 R15
		end else if (state == CRS_ST_LOAD && i_flash_word_ack) begin
			words_left <= words_left - 8'h01;
		end
	end

	assign o_flash_load_req       = (state == CRS_ST_LOAD);
	assign o_flash_load_words     = words_left;
	assign o_flash_load_func_only = (cur_kind == CRS_LOAD_FUNC);

	// done flags rise only once no load is queued, so polling never sees a stale one
	logic load_done;
	wire  load_finished = (state == CRS_ST_DONE) && (next_state == CRS_ST_IDLE);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			load_done <= 1'b0;
			func_done <= 1'b0;
			fw_err    <= CRS_FW_ERR_NONE;
		end else if (load_finished) begin
			load_done <= 1'b1; // R20
			func_done <= 1'b1; // R14
		end else if (want_full || want_func) begin
			load_done <= 1'b0;
			func_done <= 1'b0;
			fw_err    <= CRS_FW_ERR_NONE;
		end else if (state == CRS_ST_LOAD && i_flash_err) begin
			fw_err    <= fw_err + 4'h1;
		end
	end

	assign o_config_load_done          = load_done;
	assign o_autoload_done             = load_done;
	assign o_function_reset_done       = func_done;
	assign o_firmware_error_indication = fw_err;

endmodule

// ---- rtl/crs_pkg.sv ----
package crs_pkg;

	// reset source request vector bit positions
	localparam int CRS_SRC_W      = 6;
	localparam int CRS_SRC_PERST  = 0;
	localparam int CRS_SRC_INBAND = 1;
	localparam int CRS_SRC_D3HOT  = 2;
	localparam int CRS_SRC_FLR    = 3;
	localparam int CRS_SRC_SWRST  = 4;
	localparam int CRS_SRC_DEVRST = 5;

	// device control register bit that starts a function level reset
	localparam int CRS_DEVCTL_FLR_BIT = 15;

	// stretch of each internal reset pulse
	localparam int CRS_RST_PULSE_CYC = 16;

	// flash autoload words per load kind
	localparam logic [7:0] CRS_LOAD_FULL_WORDS = 8'h40;
	localparam logic [7:0] CRS_LOAD_FUNC_WORDS = 8'h10;

	// firmware error code meaning no error
	localparam logic [3:0] CRS_FW_ERR_NONE = 4'h0;

	// load kind
	typedef enum logic [1:0] {
		CRS_LOAD_NONE = 2'b00,
		CRS_LOAD_FULL = 2'b01,
		CRS_LOAD_FUNC = 2'b10
	} crs_load_t;

	typedef enum logic [1:0] {
		CRS_ST_IDLE  = 2'b00,
		CRS_ST_RESET = 2'b01,
		CRS_ST_LOAD  = 2'b10,
		CRS_ST_DONE  = 2'b11
	} crs_state_t;

endpackage

// ---- rtl/crs_sync_rst.sv ----
`timescale 1ns/1ps
// two-stage reset synchroniser; reset assertion taken on the next edge, release after two edges
module crs_sync_rst
	import crs_pkg::*;
(
	// clock and master reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// combined reset request, active high
	input  wire logic i_req,
	// synchronised domain reset
	output logic      o_rst_n
);

	logic stage1;
	logic stage2;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_req) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= 1'b1;
			stage2 <= stage1;
		end
	end

	assign o_rst_n = stage2;

endmodule

// ---- verif/crs_reset_ctrl_assertions.sv ----
`timescale 1ns/1ps
module crs_reset_ctrl_assertions
	import crs_pkg::*;
#(
	parameter int PULSE_CYC = CRS_RST_PULSE_CYC,
	parameter int TXD_W     = 8
)(
	// clock and reset
	input wire logic             i_clk,
	input wire logic             i_rst_n,
	// reset sources
	input wire logic             i_pcie_fundamental_reset_pin_n,
	input wire logic             i_inband_reset_msg,
	input wire logic             i_link_to_detect,
	input wire logic             i_devctl_wr,
	input wire logic [15:0]      i_devctl_wdata,
	input wire logic             i_bus_master_enable,
	input wire logic             i_trans_pending_set,
	input wire logic             i_port_software_reset,
	input wire logic             i_device_software_reset,
	input wire logic             i_flash_reload_request,
	// observed outputs
	input wire logic             o_pcie_rst_n,
	input wire logic             o_port_rst_n,
	input wire logic             o_func_rst_n,
	input wire logic             o_flows_disable,
	input wire logic             o_drop_pending_reads,
	input wire logic             o_discard_unexpected_cpl,
	input wire logic             o_msi_disable,
	input wire logic             o_flash_load_req,
	input wire logic             o_function_reset_done,
	input wire logic             o_transactions_pending,
	input wire logic             o_flr_active,
	input wire logic [TXD_W-1:0] o_txd
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// four low samples cover the two-flop pin synchroniser
	chk_pin_holds_pcie: assert property (
		(!i_pcie_fundamental_reset_pin_n)[*4] |=> !o_pcie_rst_n)
		else $error("pcie reset released while pin low");
	chk_pin_release_port: assert property (
		$rose(i_pcie_fundamental_reset_pin_n) |-> ##[1:8] !o_port_rst_n)
		else $error("no port reset after pin release");
	chk_inband_port: assert property (
		(i_inband_reset_msg || i_link_to_detect) |-> ##[1:3] !o_port_rst_n)
		else $error("no reset after in-band request");
	chk_flr_starts: assert property (
		(i_devctl_wr && i_devctl_wdata[CRS_DEVCTL_FLR_BIT])
		|=> o_flr_active ##[0:2] !o_func_rst_n)
		else $error("flr did not reset function");
	chk_flr_blocks: assert property (
		o_flr_active |-> o_flows_disable && o_drop_pending_reads && o_discard_unexpected_cpl)
		else $error("flr left flows or reads open");
	chk_bme_off: assert property (
		!i_bus_master_enable |-> o_msi_disable && o_flows_disable && o_drop_pending_reads)
		else $error("master disable not applied");
	chk_swrst_txd: assert property (
		(i_port_software_reset || i_device_software_reset) |-> ##2 (o_txd == '0)[*8])
		else $error("tx data not forced to zero");
	chk_swrst_port: assert property (
		i_port_software_reset |-> ##2 !o_port_rst_n && !o_function_reset_done)
		else $error("port reset or done flag wrong");
	chk_swrst_keeps_pcie: assert property (
		(i_port_software_reset && o_pcie_rst_n && i_pcie_fundamental_reset_pin_n)
		|-> ##2 o_pcie_rst_n)
		else $error("port reset touched pcie");
	chk_flr_clears_pend: assert property (
		($fell(o_flr_active) && !i_trans_pending_set) |-> ##[0:2] !o_transactions_pending)
		else $error("pending bit kept after flr");
	chk_reload_starts: assert property (i_flash_reload_request |-> ##[1:40] o_flash_load_req)
		else $error("flash reload gave no load");
endmodule

bind crs_reset_ctrl crs_reset_ctrl_assertions #(.PULSE_CYC(PULSE_CYC), .TXD_W(TXD_W)) u_chk (
	.i_clk, .i_rst_n, .i_pcie_fundamental_reset_pin_n, .i_inband_reset_msg, .i_link_to_detect,
	.i_devctl_wr, .i_devctl_wdata, .i_bus_master_enable, .i_trans_pending_set,
	.i_port_software_reset, .i_device_software_reset, .i_flash_reload_request,
	.o_pcie_rst_n, .o_port_rst_n, .o_func_rst_n, .o_flows_disable, .o_drop_pending_reads,
	.o_discard_unexpected_cpl, .o_msi_disable, .o_flash_load_req, .o_function_reset_done,
	.o_transactions_pending, .o_flr_active, .o_txd);

// ---- verif/crs_flash_model.sv ----
`timescale 1ns/1ps
module crs_flash_model (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// load handshake
	input  wire logic i_load_req,
	input  wire logic i_slow,
	output logic      o_word_ack
);
	logic [1:0] gap;
	// acks never back to back, so the last word is not acked twice
	always_ff @(posedge i_clk) begin
		gap <= (!i_rst_n || gap == 2'h0) ? (i_slow ? 2'h3 : 2'h0) : gap - 2'h1;
		o_word_ack <= i_rst_n && i_load_req && gap == 2'h0 && !o_word_ack;
	end
endmodule

// ---- verif/crs_reset_ctrl_bench.sv ----
`timescale 1ns/1ps
module crs_reset_ctrl_bench
	import crs_pkg::*;
;
	logic        i_clk = 1'h0, i_rst_n = 1'h0, pin_n = 1'h0, slow = 1'h0, keep = 1'h0, bme = 1'h1;
	logic [10:0] ev = '0;
	logic [15:0] wdata = 16'h0;
	logic [7:0]  txd = 8'h0, otxd, lwords;
	logic [3:0]  fwerr;
	logic        prst, port, dma, cfg, func, flows, drop, disc, msi;
	logic        lreq, lfunc, cld, ald, frd, tp, flr, ack;
	logic [31:0] seed = 32'hD971D373;
	int          n_errors = 0, check_count = 0, k;
	int          seq[3] = '{0, 3, 2};

	always #4 i_clk = ~i_clk;

	crs_reset_ctrl u_dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pcie_fundamental_reset_pin_n(pin_n),
		.i_inband_reset_msg(ev[4]), .i_link_to_detect(ev[5]), .i_l23_ready_entry(ev[6]),
		.i_d3cold_exit(ev[7]), .i_d3hot_to_d0(ev[8]), .i_keep_config_on_wake(keep),
		.i_devctl_wr(ev[3]), .i_devctl_wdata(wdata), .i_bus_master_enable(bme),
		.i_trans_pending_set(ev[9]), .i_port_software_reset(ev[0]),
		.i_device_software_reset(ev[1]), .i_flash_reload_request(ev[2]),
		.i_flash_word_ack(ack), .i_flash_err(ev[10]), .i_txd(txd),
		.o_pcie_rst_n(prst), .o_port_rst_n(port), .o_dma_rst_n(dma), .o_cfg_nonsticky_rst_n(cfg),
		.o_func_rst_n(func), .o_flows_disable(flows), .o_drop_pending_reads(drop),
		.o_discard_unexpected_cpl(disc), .o_msi_disable(msi), .o_flash_load_req(lreq),
		.o_flash_load_words(lwords), .o_flash_load_func_only(lfunc), .o_config_load_done(cld),
		.o_autoload_done(ald), .o_function_reset_done(frd), .o_transactions_pending(tp),
		.o_firmware_error_indication(fwerr), .o_flr_active(flr), .o_txd(otxd));

	crs_flash_model u_flash (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_load_req(lreq), .i_slow(slow),
		.o_word_ack(ack));

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// port reset, flr and flash reload reload only the function's words
	function logic [7:0] exp_words(input int e);
		return (e == 0 || e == 2 || e == 3) ? CRS_LOAD_FUNC_WORDS : CRS_LOAD_FULL_WORDS;
	endfunction

	task results;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task fire(input int e);
		ev[e] = 1'h1;
		step(1);
		ev[e] = 1'h0;
	endtask

	task limit(input int i, input int lim);
		if (i >= lim) begin
			n_errors++;
			$display("CHECK FAILED %0t wait ran out", $time);
			results();
		end
	endtask

	task wait_req;
		int i;
		for (i = 0; i < 100 && lreq !== 1'h1; i++)
			step(1);
		limit(i, 100);
	endtask

	// done flags drop one edge after the event, so skip past that first
	task wait_done;
		int i;
		step(2);
		for (i = 0; i < 3000
			&& !(cld === 1'h1 && ald === 1'h1 && frd === 1'h1 && lreq === 1'h0); i++)
			step(1);
		limit(i, 3000);
	endtask

	initial begin
		step(12);
		i_rst_n = 1'h1;
		wait_req();
		chk(lwords, CRS_LOAD_FULL_WORDS);
		step(2);
		chk(prst, 1'h0);
		pin_n = 1'h1;
		wait_done();
		chk(fwerr, CRS_FW_ERR_NONE);
		chk(prst, 1'h1);
		txd = 8'hA5;
		foreach (seq[j]) begin
			wdata = 16'h8000;
			fire(seq[j]);
			if (seq[j] == 0) begin
				chk(frd, 1'h0);
				chk(dma, 1'h1);
			end
			wait_req();
			chk(lwords, exp_words(seq[j]));
			chk(lfunc, 1'h1);
			wait_done();
			chk(otxd, txd);
		end
		fire(9);
		step(1);
		chk(tp, 1'h1);
		fire(3);
		wait_done();
		chk(tp, 1'h0);
		wdata = 16'h7FFF;
		fire(3);
		chk(flr, 1'h0);
		bme = 1'h0;
		step(1);
		chk({msi, flows, drop}, 3'h7);
		chk(port, 1'h1);
		chk(dma, 1'h0);
		bme = 1'h1;
		step(1);
		chk(msi, 1'h0);
		pin_n = 1'h0;
		step(6);
		chk(prst, 1'h0);
		pin_n = 1'h1;
		step(8);
		chk(port, 1'h0);
		chk(cfg, 1'h0);
		wait_done();
		chk(prst, 1'h1);
		repeat (24) begin
			seed = lfsr(seed);
			k = int'(seed[3:0]) % 9;
			txd = seed[15:8];
			slow = seed[16];
			keep = seed[17];
			wdata = {1'h1, seed[30:16]};
			fire(k);
			if (k < 2) begin
				step(2);
				chk(otxd, 8'h0);
			end
			wait_done();
			chk(fwerr, CRS_FW_ERR_NONE);
		end
		fire(0);
		wait_req();
		fire(10);
		step(1);
		chk(fwerr, 4'h1);
		wait_done();
		results();
	end
endmodule
